// [hw/dpmc_pkg.sv]
// package: constants, timing and carriers for the dual-port memory controller
package dpmc_pkg;

    // ***********************************************************
    // widths of the driven memory and of the bus address
    // ***********************************************************
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int BUS_AW = 5;

    // ***********************************************************
    // register byte offsets
    // ***********************************************************
    localparam logic [BUS_AW-1:0] OFS_CTRL   = 5'h00;
    localparam logic [BUS_AW-1:0] OFS_ADDR   = 5'h04;
    localparam logic [BUS_AW-1:0] OFS_WDATA  = 5'h08;
    localparam logic [BUS_AW-1:0] OFS_STATUS = 5'h0C;
    localparam logic [BUS_AW-1:0] OFS_RDATA  = 5'h10;

    // ***********************************************************
    // field positions
    // ***********************************************************
    localparam int CTRL_WRITE_BIT = 0;
    localparam int CTRL_READ_BIT  = 1;
    localparam int CTRL_SELA_BIT  = 2;
    localparam int CTRL_SELB_BIT  = 3;
    localparam int PORTB_LSB      = 16;
    localparam int STAT_BUSY_BIT  = 0;

    // ***********************************************************
    // values after reset
    // ***********************************************************
    localparam logic [1:0]  SEL_RESET  = 2'h0;
    localparam logic [31:0] WORD_ZERO  = 32'h0000_0000;

    // ***********************************************************
    // timing, in ns, and cycle counts at the clock rate
    // ***********************************************************
    localparam int CLK_MHZ        = 20;
    localparam int T_ADDR_SETUP   = 15;
    localparam int T_ADDR_HOLD    = 5;
    localparam int T_DATA_HOLD    = 10;
    localparam int T_WE_PULSE     = 45;
    localparam int T_ACCESS       = 40;
    localparam int SYNC_DEPTH     = 3;

    // least time rounded up to whole cycles, never below one
    function automatic int cyclesMin(input int ns);
        int c;
        c = (ns * CLK_MHZ + 999) / 1000;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int SETUP_CYC  = cyclesMin(T_ADDR_SETUP);
    localparam int PULSE_CYC  = cyclesMin(T_WE_PULSE);
    localparam int HOLD_CYC   = (cyclesMin(T_ADDR_HOLD) > cyclesMin(T_DATA_HOLD)) ?
                                cyclesMin(T_ADDR_HOLD) : cyclesMin(T_DATA_HOLD);
    localparam int ACCESS_CYC = cyclesMin(T_ACCESS) + SYNC_DEPTH;
    localparam int CNT_W      = 4;

    // ***********************************************************
    // carriers
    // ***********************************************************
    typedef struct packed {
        logic [ADDR_W-1:0] addrA;
        logic [ADDR_W-1:0] addrB;
        logic [DATA_W-1:0] dataIn;
        logic              weHigh;
        logic              weLow_n;
        logic              selA_n;
        logic              selB_n;
    } dpmc_pins_s;

    typedef struct packed {
        logic [DATA_W-1:0] outA;
        logic [DATA_W-1:0] outB;
    } dpmc_outs_s;

    typedef struct packed {
        logic [BUS_AW-1:0] address;
        logic              read;
        logic              write;
        logic [31:0]       writedata;
    } dpmc_avreq_s;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_SETUP = 3'h1,
        ST_PULSE = 3'h3,
        ST_HOLD  = 3'h2,
        ST_WAIT  = 3'h6
    } dpmc_state_e;

endpackage

// [hw/dpmc_ctrl.sv]
// controller that drives a dual-port memory through its pins, ordered over avalon-mm
//
// Implementation choices: the register addresses and the Avalon-MM register port.
module dpmc_ctrl #(
    parameter int AW = dpmc_pkg::ADDR_W,
    parameter int DW = dpmc_pkg::DATA_W
) (
    // clock and reset
    input  wire logic                clock,
    input  wire logic                rst_n,
    // avalon-mm slave
    input  wire dpmc_pkg::dpmc_avreq_s avReq,
    output logic [31:0]              avReaddata,
    output logic                     avWaitrequest,
    // memory pins
    output dpmc_pkg::dpmc_pins_s     memPins,
    input  wire dpmc_pkg::dpmc_outs_s memOuts
);

    // ***********************************************************
    // state
    // ***********************************************************
    dpmc_pkg::dpmc_pins_s  pins_r,   pins_nxt;
    dpmc_pkg::dpmc_state_e state_r,  state_nxt;
    logic [dpmc_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
    logic [AW-1:0]         addrA_r,  addrA_nxt;
    logic [AW-1:0]         addrB_r,  addrB_nxt;
    logic [DW-1:0]         wdata_r,  wdata_nxt;
    logic [1:0]            sel_r,    sel_nxt;
    logic [DW-1:0]         rdA_r,    rdA_nxt;
    logic [DW-1:0]         rdB_r,    rdB_nxt;
    logic                  isRead_r, isRead_nxt;
    logic [31:0]           rdata_r,  rdata_nxt;
    logic                  wait_r,   wait_nxt;

    // input synchroniser, three stages per bit
    dpmc_pkg::dpmc_outs_s  sync1_r, sync2_r, sync3_r, stable_r, stable_nxt;

    logic                  busy;
    logic                  accept;
    // control write accepted while idle; it starts an operation only if a start bit is set
    logic                  ctrlStart;

    // ***********************************************************
    // helpers
    // ***********************************************************
    function automatic logic [dpmc_pkg::CNT_W-1:0] toCnt(input int n);
        return dpmc_pkg::CNT_W'(n - 1);
    endfunction

    function automatic logic [31:0] packPorts(input logic [DW-1:0] a, input logic [DW-1:0] b);
        logic [31:0] w;
        w = dpmc_pkg::WORD_ZERO;
        w[DW-1:0] = a;
        w[dpmc_pkg::PORTB_LSB +: DW] = b;
        return w;
    endfunction

    assign busy   = (state_r != dpmc_pkg::ST_IDLE);
    assign accept = (avReq.read || avReq.write) && !wait_r;
    // a start that lands while busy is dropped with the rest of the write
    assign ctrlStart = accept && avReq.write && !busy && (avReq.address == dpmc_pkg::OFS_CTRL);

    // ***********************************************************
    // synchroniser: a change counts once stages two and three agree
    // ***********************************************************
    // a pin change shows in stable_nxt three edges after it, and in stable_r one edge later
    always_comb begin
        stable_nxt = stable_r;
        if (sync2_r == sync3_r) begin
            stable_nxt = sync3_r;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sync1_r  <= '0;
            sync2_r  <= '0;
            sync3_r  <= '0;
            stable_r <= '0;
        end else begin
            sync1_r  <= memOuts;
            sync2_r  <= sync1_r;
            sync3_r  <= sync2_r;
            stable_r <= stable_nxt;
        end
    end

    // ***********************************************************
    // bus answer
    // ***********************************************************
    // one wait cycle per access keeps readdata registered, at the cost of two cycles per access;
    // readdata is decoded a cycle ahead from the registers as they stand
    always_comb begin
        rdata_nxt = rdata_r;
        wait_nxt  = 1'b1;
        if ((avReq.read || avReq.write) && wait_r) begin
            wait_nxt = 1'b0;
            if (avReq.address == dpmc_pkg::OFS_CTRL) begin
                rdata_nxt = dpmc_pkg::WORD_ZERO;
                rdata_nxt[dpmc_pkg::CTRL_SELA_BIT] = sel_r[0];
                rdata_nxt[dpmc_pkg::CTRL_SELB_BIT] = sel_r[1];
            end else if (avReq.address == dpmc_pkg::OFS_ADDR) begin
                rdata_nxt = dpmc_pkg::WORD_ZERO;
                rdata_nxt[AW-1:0] = addrA_r;
                rdata_nxt[dpmc_pkg::PORTB_LSB +: AW] = addrB_r;
            end else if (avReq.address == dpmc_pkg::OFS_WDATA) begin
                rdata_nxt = dpmc_pkg::WORD_ZERO;
                rdata_nxt[DW-1:0] = wdata_r;
            end else if (avReq.address == dpmc_pkg::OFS_STATUS) begin
                rdata_nxt = dpmc_pkg::WORD_ZERO;
                rdata_nxt[dpmc_pkg::STAT_BUSY_BIT] = busy;
            end else if (avReq.address == dpmc_pkg::OFS_RDATA) begin
                rdata_nxt = packPorts(rdA_r, rdB_r);
            end else begin
                rdata_nxt = dpmc_pkg::WORD_ZERO;
            end
        end
    end

    // readdata stands from its answer until the next one
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r <= dpmc_pkg::WORD_ZERO;
            wait_r  <= 1'b1;
        end else begin
            rdata_r <= rdata_nxt;
            wait_r  <= wait_nxt;
        end
    end

    // ***********************************************************
    // order registers
    // ***********************************************************
    // writes take effect at the edge where waitrequest is low;
    // while busy they are dropped so the pins keep address and data through the operation
    always_comb begin
        addrA_nxt = addrA_r;
        addrB_nxt = addrB_r;
        wdata_nxt = wdata_r;
        sel_nxt   = sel_r;
        if (accept && avReq.write && !busy) begin
            if (avReq.address == dpmc_pkg::OFS_CTRL) begin
                // start bits are strobes; only the selects are kept
                sel_nxt = {avReq.writedata[dpmc_pkg::CTRL_SELB_BIT], avReq.writedata[dpmc_pkg::CTRL_SELA_BIT]};
            end else if (avReq.address == dpmc_pkg::OFS_ADDR) begin
                addrA_nxt = avReq.writedata[AW-1:0];
                addrB_nxt = avReq.writedata[dpmc_pkg::PORTB_LSB +: AW];
            end else if (avReq.address == dpmc_pkg::OFS_WDATA) begin
                wdata_nxt = avReq.writedata[DW-1:0];
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            addrA_r <= '0;
            addrB_r <= '0;
            wdata_r <= '0;
            sel_r   <= dpmc_pkg::SEL_RESET;
        end else begin
            addrA_r <= addrA_nxt;
            addrB_r <= addrB_nxt;
            wdata_r <= wdata_nxt;
            sel_r   <= sel_nxt;
        end
    end

    // ***********************************************************
    // pin sequencer
    // ***********************************************************
    always_comb begin
        state_nxt  = state_r;
        cnt_nxt    = cnt_r;
        rdA_nxt    = rdA_r;
        rdB_nxt    = rdB_r;
        isRead_nxt = isRead_r;
        pins_nxt   = pins_r;

        // a control write while idle with a start bit set starts one operation; write wins when both start bits are set
        if (ctrlStart) begin
            if (avReq.writedata[dpmc_pkg::CTRL_WRITE_BIT]) begin
                state_nxt  = dpmc_pkg::ST_SETUP;
                cnt_nxt    = toCnt(dpmc_pkg::SETUP_CYC);
                isRead_nxt = 1'b0;
            end else if (avReq.writedata[dpmc_pkg::CTRL_READ_BIT]) begin
                state_nxt  = dpmc_pkg::ST_WAIT;
                cnt_nxt    = toCnt(dpmc_pkg::ACCESS_CYC);
                isRead_nxt = 1'b1;
            end
        end

        // pins follow the sequencer; addresses only change while idle
        // selects move only with a control write while idle: they only gate the outputs, never the stored words
        pins_nxt.selA_n = !sel_nxt[0];
        pins_nxt.selB_n = !sel_nxt[1];
        if (!busy) begin
            pins_nxt.addrA  = addrA_nxt;
            pins_nxt.addrB  = addrB_nxt;
            pins_nxt.dataIn = wdata_nxt;
        end

        case (state_r)
            dpmc_pkg::ST_IDLE: begin
                // both enables parked at their inactive levels between operations
                pins_nxt.weHigh  = 1'b0;
                pins_nxt.weLow_n = 1'b1;
            end
            dpmc_pkg::ST_SETUP: begin
                // address and data stood one or more cycles before the pulse
                if (cnt_r == '0) begin
                    state_nxt        = dpmc_pkg::ST_PULSE;
                    cnt_nxt          = toCnt(dpmc_pkg::PULSE_CYC);
                    pins_nxt.weHigh  = 1'b1;
                    pins_nxt.weLow_n = 1'b0;
                end else begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
            dpmc_pkg::ST_PULSE: begin
                if (cnt_r == '0) begin
                    state_nxt        = dpmc_pkg::ST_HOLD;
                    cnt_nxt          = toCnt(dpmc_pkg::HOLD_CYC);
                    pins_nxt.weHigh  = 1'b0;
                    pins_nxt.weLow_n = 1'b1;
                end else begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
            dpmc_pkg::ST_HOLD: begin
                // address and data held past the end of the pulse
                if (cnt_r == '0) begin
                    state_nxt = dpmc_pkg::ST_IDLE;
                end else begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
            dpmc_pkg::ST_WAIT: begin
                // access time plus synchroniser latency before capture
                if (cnt_r == '0) begin
                    state_nxt = dpmc_pkg::ST_IDLE;
                    if (isRead_r) begin
                        // take the value entering stable_r at this edge: stable_r itself is one edge
                        // behind and would still show the words from before the selects moved
                        rdA_nxt = stable_nxt.outA;
                        rdB_nxt = stable_nxt.outB;
                    end
                end else begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
            default: begin
                state_nxt        = dpmc_pkg::ST_IDLE;
                pins_nxt.weHigh  = 1'b0;
                pins_nxt.weLow_n = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            // pins leave reset parked: enables inactive, both ports deselected
            state_r  <= dpmc_pkg::ST_IDLE;
            cnt_r    <= '0;
            rdA_r    <= '0;
            rdB_r    <= '0;
            isRead_r <= 1'b0;
            pins_r   <= '{addrA: '0, addrB: '0, dataIn: '0, weHigh: 1'b0, weLow_n: 1'b1,
                          selA_n: 1'b1, selB_n: 1'b1};
        end else begin
            state_r  <= state_nxt;
            cnt_r    <= cnt_nxt;
            rdA_r    <= rdA_nxt;
            rdB_r    <= rdB_nxt;
            isRead_r <= isRead_nxt;
            pins_r   <= pins_nxt;
        end
    end

    // ***********************************************************
    // outputs
    // ***********************************************************
    // memory-side behaviours (shared array, write-through to outputs) are relied on, not built
    assign memPins       = pins_r;
    assign avReaddata    = rdata_r;
    assign avWaitrequest = wait_r;

endmodule

// [sim/dpmc_ctrl_checker.sv]
// checker: port assertions on the dual-port memory controller
module dpmc_ctrl_checker (
    // clock and reset
    input wire logic                  clock,
    input wire logic                  rst_n,
    // avalon-mm side
    input wire dpmc_pkg::dpmc_avreq_s avReq,
    input wire logic [31:0]           avReaddata,
    input wire logic                  avWaitrequest,
    // memory pins
    input wire dpmc_pkg::dpmc_pins_s  memPins,
    input wire dpmc_pkg::dpmc_outs_s  memOuts
);
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************
    // helpers and assertions
    // ****************************************
    logic ctrlTaken;
    assign ctrlTaken = avReq.write && !avWaitrequest && (avReq.address == dpmc_pkg::OFS_CTRL);

    default clocking dcb @(posedge clock); endclocking
    default disable iff (!rst_n);

    chk_bus_answer: assert property ((avReq.read || avReq.write) && avWaitrequest |=> !avWaitrequest)
        else $error("request not answered one cycle later");
    chk_wait_single: assert property (!avWaitrequest |=> avWaitrequest)
        else $error("waitrequest low for more than one cycle");
    chk_wait_cause: assert property ($fell(avWaitrequest) |-> $past(avReq.read || avReq.write))
        else $error("answer without a request");
    chk_we_pair: assert property (memPins.weHigh == !memPins.weLow_n)
        else $error("write enables not at matching levels");
    // one 50 ns cycle already covers the least pulse width
    chk_pulse_width: assert property ($rose(memPins.weHigh) |=> $fell(memPins.weHigh))
        else $error("write pulse not one cycle long");
    chk_write_cause: assert property ($rose(memPins.weHigh) |-> $past(ctrlTaken && avReq.writedata[0], 2))
        else $error("write pulse without a start two cycles before");
    chk_addr_setup: assert property ($rose(memPins.weHigh) |-> $stable(memPins.addrA) && $stable(memPins.dataIn))
        else $error("address or data moved at pulse start");
    chk_addr_hold: assert property ($fell(memPins.weHigh) |-> $stable(memPins.addrA) && $stable(memPins.dataIn))
        else $error("address or data moved at pulse end");
    chk_sela_cause: assert property (!$stable(memPins.selA_n) |-> $past(ctrlTaken))
        else $error("port a select moved without a control write");
    chk_selb_cause: assert property (!$stable(memPins.selB_n) |-> $past(ctrlTaken))
        else $error("port b select moved without a control write");
endmodule

bind dpmc_ctrl dpmc_ctrl_checker u_dpmc_ctrl_checker (.clock(clock), .rst_n(rst_n), .avReq(avReq),
    .avReaddata(avReaddata), .avWaitrequest(avWaitrequest), .memPins(memPins), .memOuts(memOuts));

// [sim/dpmc_mem_model.sv]
// model: behavioural dual-port memory that the controller drives
module dpmc_mem_model #(
    parameter int AW = dpmc_pkg::ADDR_W,
    parameter int DW = dpmc_pkg::DATA_W
) (
    // pins from the controller
    input wire dpmc_pkg::dpmc_pins_s pins,
    // output sets back to the controller
    output dpmc_pkg::dpmc_outs_s     outs
);
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************
    // storage and output sets
    // ****************************************
    logic [DW-1:0] store [2**AW];
    logic [DW-1:0] inLatch;
    logic          writing;

    // preset pattern so a read before any write still has a known answer
    initial begin
        for (int i = 0; i < 2**AW; i++) store[i] = DW'(8'hC3 + i);
        inLatch = '0;
    end

    assign writing = pins.weHigh & ~pins.weLow_n;

    always @(posedge writing) begin
        inLatch = pins.dataIn;
        store[pins.addrA] = pins.dataIn;
    end

    // open-collector set: a deselected port floats to the pull-up level
    assign outs.outA = pins.selA_n ? '1 : (writing ? inLatch : store[pins.addrA]);
    assign outs.outB = pins.selB_n ? '1 :
                       ((writing && pins.addrB == pins.addrA) ? inLatch : store[pins.addrB]);
endmodule

// [sim/dpmc_ctrl_bench.sv]
// testbench: register-level tests of the controller against the memory model
module dpmc_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************
    // clock, reset and wiring
    // ****************************************
    logic                  clock = 1'b0;
    logic                  rst_n = 1'b0;
    dpmc_pkg::dpmc_avreq_s avReq = '0;
    logic [31:0]           avReaddata;
    logic                  avWaitrequest;
    dpmc_pkg::dpmc_pins_s  memPins;
    dpmc_pkg::dpmc_outs_s  memOuts;
    int                    fail_count = 0;
    int                    num_checks = 0;
    logic [7:0]            shadow [16];
    logic [31:0]           rd;

    always #25 clock = ~clock;

    dpmc_ctrl u_dpmc_ctrl (.clock(clock), .rst_n(rst_n), .avReq(avReq), .avReaddata(avReaddata),
                           .avWaitrequest(avWaitrequest), .memPins(memPins), .memOuts(memOuts));
    dpmc_mem_model u_dpmc_mem_model (.pins(memPins), .outs(memOuts));

    // ****************************************
    // tasks
    // ****************************************
    task automatic final_report();
        if (fail_count == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // request stands until waitrequest is sampled low; one idle edge keeps drivers apart
    task automatic access(input logic rd_en, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avReq <= '{a, rd_en, !rd_en, d};
        do begin
            @(posedge clock);
            n++;
        end while (avWaitrequest !== 1'b0 && n < 20);
        if (avWaitrequest !== 1'b0) fail_count++;
        rd = avReaddata;
        avReq <= '0;
        @(posedge clock);
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            access(1'b1, dpmc_pkg::OFS_STATUS, 32'h0);
            n++;
        end while (rd[0] !== 1'b0 && n < 20);
        check("status busy", 32'h0, rd);
    endtask

    task automatic mem_write(input logic [3:0] a, input logic [3:0] b, input logic [7:0] d);
        access(1'b0, dpmc_pkg::OFS_ADDR, {12'h000, b, 12'h000, a});
        access(1'b0, dpmc_pkg::OFS_WDATA, {24'h000000, d});
        access(1'b0, dpmc_pkg::OFS_CTRL, 32'h0000000F);
        wait_idle();
        shadow[a] = d;
    endtask

    task automatic mem_read(input logic [3:0] a, input logic [3:0] b, input logic [1:0] sel);
        access(1'b0, dpmc_pkg::OFS_ADDR, {12'h000, b, 12'h000, a});
        access(1'b0, dpmc_pkg::OFS_CTRL, {28'h0000000, sel, 2'h2});
        access(1'b1, dpmc_pkg::OFS_STATUS, 32'h0);
        check("status busy during read", 32'h1, rd);
        wait_idle();
        access(1'b1, dpmc_pkg::OFS_RDATA, 32'h0);
        check("read words", {8'h00, sel[1] ? shadow[b] : 8'hFF, 8'h00, sel[0] ? shadow[a] : 8'hFF}, rd);
    endtask

    // ****************************************
    // tests
    // ****************************************
    initial begin
        for (int i = 0; i < 16; i++) shadow[i] = 8'(8'hC3 + i);
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        check("idle pins", 32'h7, {28'h0, memPins.weHigh, memPins.weLow_n, memPins.selA_n, memPins.selB_n});
        for (int i = 0; i < 6; i++) begin
            access(1'b1, 5'(i * 4), 32'h0);
            check("reset register", 32'h0, rd);
        end
        access(1'b0, 5'h14, 32'hFFFFFFFF);
        access(1'b1, 5'h14, 32'h0);
        check("unmapped", 32'h0, rd);
        mem_read(4'h2, 4'h9, 2'h3);
        mem_read(4'h5, 4'h5, 2'h1);
        mem_read(4'h5, 4'h5, 2'h2);
        mem_read(4'h5, 4'h6, 2'h0);
        for (int i = 0; i < 4; i++) mem_write(4'(i * 5), 4'(15 - i), 8'(8'h3C ^ (i * 8'h11)));
        mem_read(4'h0, 4'hF, 2'h3);
        mem_read(4'hA, 4'h5, 2'h3);
        mem_read(4'hF, 4'hF, 2'h3);
        access(1'b1, dpmc_pkg::OFS_CTRL, 32'h0);
        check("ctrl readback", 32'h0000000C, rd);
        // a data write that lands while busy must be dropped
        access(1'b0, dpmc_pkg::OFS_CTRL, 32'h0000000D);
        access(1'b0, dpmc_pkg::OFS_WDATA, 32'h000000AA);
        wait_idle();
        access(1'b1, dpmc_pkg::OFS_WDATA, 32'h0);
        check("wdata kept", {24'h000000, shadow[15]}, rd);
        mem_read(4'hF, 4'h0, 2'h3);
        final_report();
    end

    initial begin
        #200us;
        fail_count++;
        final_report();
    end
endmodule
